// [common/cbtu_pkg.sv]
// Constants and types for the channel baseline tracking block
package cbtu_pkg;
	localparam int CBTU_NCH = 3;
	localparam int CBTU_CW = 16;
	localparam int CBTU_BETA_W = 4;
	localparam int CBTU_SEL_W = 2;
	localparam int CBTU_MASK_W = 2 * CBTU_NCH;
	localparam int CBTU_PCT_W = 8;
	localparam int CBTU_PROD_W = CBTU_CW + CBTU_PCT_W;
	localparam int CBTU_WEIGHT_W = 16;
	localparam int CBTU_WPROD_W = 36;
	localparam int CBTU_WEIGHT_SHIFT = 12;
	localparam int CBTU_PCT_SHIFT = 7;
	localparam int CBTU_PROX_BIT = 0;
	localparam int CBTU_TOUCH_BIT = 1;
	localparam logic [CBTU_CW-1:0] CBTU_AVG_MAX = 16'hffff;
	localparam logic [CBTU_CW-1:0] CBTU_CNT_MAX = 16'hffff;
	typedef enum logic [1:0] {CBTU_INDEP, CBTU_REFER, CBTU_FOLLOW} cbtu_role_type;
	typedef struct packed {
		logic [CBTU_NCH-1:0] seeded;
		logic [CBTU_NCH-1:0][CBTU_CW-1:0] long_term_average;
		logic [CBTU_NCH-1:0][CBTU_CW-1:0] act;
		logic [CBTU_NCH-1:0][CBTU_CW-1:0] mov;
		logic [CBTU_NCH-1:0][CBTU_CW-1:0] snap;
		logic [CBTU_NCH-1:0] snapped;
		logic [CBTU_NCH-1:0][CBTU_CW-1:0] settle_cnt;
		logic [CBTU_NCH-1:0][CBTU_CW-1:0] enter_cnt;
		logic [CBTU_NCH-1:0][CBTU_CW-1:0] exit_cnt;
		logic [CBTU_NCH-1:0][CBTU_CW-1:0] still_cnt;
		logic [CBTU_NCH-1:0] mov_status;
		logic [CBTU_NCH-1:0] clear;
		logic [CBTU_NCH-1:0] ati_block;
	} cbtu_state_type;
endpackage : cbtu_pkg

// [rtl/cbtu_core.sv]
// Per-channel drift, release and movement tracking of sensing counts
`timescale 1ns/10ps
module cbtu_core
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic sample_i,
	input wire logic [cbtu_pkg::CBTU_NCH-1:0][cbtu_pkg::CBTU_CW-1:0] counts_i,
	input wire logic [cbtu_pkg::CBTU_NCH-1:0] prox_i,
	input wire logic [cbtu_pkg::CBTU_NCH-1:0] touch_i,
	input wire cbtu_pkg::cbtu_role_type [cbtu_pkg::CBTU_NCH-1:0] role_i,
	input wire logic [cbtu_pkg::CBTU_NCH-1:0][cbtu_pkg::CBTU_SEL_W-1:0] reference_select_i,
	input wire logic [cbtu_pkg::CBTU_NCH-1:0][cbtu_pkg::CBTU_MASK_W-1:0] follower_event_mask_i,
	input wire logic [cbtu_pkg::CBTU_NCH-1:0][cbtu_pkg::CBTU_WEIGHT_W-1:0] follower_weight_i,
	input wire logic [cbtu_pkg::CBTU_BETA_W-1:0] lta_beta_i,
	input wire logic [cbtu_pkg::CBTU_NCH-1:0] rate_release_enable_i,
	input wire logic [cbtu_pkg::CBTU_BETA_W-1:0] activation_beta_i,
	input wire logic [cbtu_pkg::CBTU_CW-1:0] settle_threshold_i,
	input wire logic [cbtu_pkg::CBTU_CW-1:0] snapshot_delay_i,
	input wire logic [cbtu_pkg::CBTU_PCT_W-1:0] release_percent_i,
	input wire logic [cbtu_pkg::CBTU_NCH-1:0] motion_hold_enable_i,
	input wire logic [cbtu_pkg::CBTU_BETA_W-1:0] movement_beta_i,
	input wire logic [cbtu_pkg::CBTU_CW-1:0] movement_threshold_i,
	input wire logic [cbtu_pkg::CBTU_CW-1:0] debounce_enter_i,
	input wire logic [cbtu_pkg::CBTU_CW-1:0] debounce_exit_i,
	input wire logic [cbtu_pkg::CBTU_CW-1:0] movement_timeout_i,
	output logic [cbtu_pkg::CBTU_NCH-1:0][cbtu_pkg::CBTU_CW-1:0] long_term_average_o,
	output logic [cbtu_pkg::CBTU_NCH-1:0][cbtu_pkg::CBTU_CW-1:0] activation_average_o,
	output logic [cbtu_pkg::CBTU_NCH-1:0][cbtu_pkg::CBTU_CW-1:0] movement_average_o,
	output logic [cbtu_pkg::CBTU_NCH-1:0][cbtu_pkg::CBTU_CW-1:0] delta_snapshot_o,
	output logic [cbtu_pkg::CBTU_NCH-1:0] movement_status_o,
	output logic [cbtu_pkg::CBTU_NCH-1:0] state_clear_o,
	output logic [cbtu_pkg::CBTU_NCH-1:0] ati_block_o
);
	import cbtu_pkg::*;

	cbtu_state_type s;
	cbtu_state_type next_s;

	// One IIR step: avg + (x - avg) / 2^beta
	function automatic logic [CBTU_CW-1:0] cbtu_iir(input logic [CBTU_CW-1:0] avg,
		input logic [CBTU_CW-1:0] x, input logic [CBTU_BETA_W-1:0] beta);
		logic signed [CBTU_CW:0] d;
		logic signed [CBTU_CW:0] st;
		logic signed [CBTU_CW+1:0] r;
		d = $signed({1'b0, x}) - $signed({1'b0, avg});
		st = d >>> beta;
		r = $signed({2'b00, avg}) + $signed({st[CBTU_CW], st});
		return r[CBTU_CW-1:0];
	endfunction : cbtu_iir

	// Signed difference a - b
	function automatic logic signed [CBTU_CW:0] cbtu_sdiff(input logic [CBTU_CW-1:0] a,
		input logic [CBTU_CW-1:0] b);
		return $signed({1'b0, a}) - $signed({1'b0, b});
	endfunction : cbtu_sdiff

	// Absolute difference
	function automatic logic [CBTU_CW-1:0] cbtu_absdiff(input logic [CBTU_CW-1:0] a,
		input logic [CBTU_CW-1:0] b);
		return (a > b) ? CBTU_CW'(a - b) : CBTU_CW'(b - a);
	endfunction : cbtu_absdiff

	// Saturating increment
	function automatic logic [CBTU_CW-1:0] cbtu_inc(input logic [CBTU_CW-1:0] c);
		return (c == CBTU_CNT_MAX) ? c : CBTU_CW'(c + 1'b1);
	endfunction : cbtu_inc

	always_comb
	begin
		logic [CBTU_NCH-1:0] evt;
		logic [CBTU_NCH-1:0] rsd;
		logic [CBTU_MASK_W-1:0] stat;
		logic [CBTU_PROD_W-1:0] prod;
		logic signed [CBTU_CW:0] chg;
		logic signed [CBTU_WPROD_W-1:0] adj;
		logic signed [CBTU_WPROD_W-1:0] sum;
		logic [CBTU_SEL_W-1:0] sel;
		evt = prox_i | touch_i;
		rsd = '0;
		stat = '0;
		prod = '0;
		chg = '0;
		adj = '0;
		sum = '0;
		sel = '0;
		next_s = s;
		next_s.clear = '0;
		for (int i = 0; i < CBTU_NCH; i++)
		begin
			stat[2 * i + CBTU_PROX_BIT] = prox_i[i];
			stat[2 * i + CBTU_TOUCH_BIT] = touch_i[i];
		end
		for (int i = 0; i < CBTU_NCH; i++)
		begin
			next_s.ati_block[i] = (role_i[i] == CBTU_REFER) && |(follower_event_mask_i[i] & stat);
		end
		if (sample_i)
		begin
			for (int i = 0; i < CBTU_NCH; i++)
			begin
				if (rate_release_enable_i[i])
				begin
					next_s.act[i] = cbtu_iir(s.act[i], counts_i[i], activation_beta_i);
					if (cbtu_absdiff(counts_i[i], s.act[i]) < settle_threshold_i)
					begin
						next_s.settle_cnt[i] = cbtu_inc(s.settle_cnt[i]);
					end
					else
					begin
						next_s.settle_cnt[i] = '0;
					end
					if (!evt[i])
					begin
						next_s.snapped[i] = 1'b0;
					end
					else if (!s.snapped[i] && next_s.settle_cnt[i] > snapshot_delay_i)
					begin
						next_s.snap[i] = cbtu_absdiff(s.long_term_average[i], counts_i[i]);
						next_s.snapped[i] = 1'b1;
					end
					prod = CBTU_PROD_W'(s.snap[i]) * CBTU_PROD_W'(release_percent_i);
					if (evt[i] && s.snapped[i] &&
						cbtu_sdiff(counts_i[i], s.act[i]) > $signed({1'b0, prod[CBTU_PROD_W-1:CBTU_PCT_SHIFT]}))
					begin
						rsd[i] = 1'b1;
					end
				end
				else
				begin
					next_s.snap[i] = '0;
					next_s.snapped[i] = 1'b0;
					next_s.settle_cnt[i] = '0;
				end
				if (motion_hold_enable_i[i])
				begin
					next_s.mov[i] = cbtu_iir(s.mov[i], counts_i[i], movement_beta_i);
					if (cbtu_absdiff(counts_i[i], s.mov[i]) > movement_threshold_i)
					begin
						next_s.enter_cnt[i] = cbtu_inc(s.enter_cnt[i]);
						next_s.exit_cnt[i] = '0;
						if (next_s.enter_cnt[i] > debounce_enter_i)
						begin
							next_s.mov_status[i] = 1'b1;
						end
					end
					else
					begin
						next_s.exit_cnt[i] = cbtu_inc(s.exit_cnt[i]);
						next_s.enter_cnt[i] = '0;
						if (next_s.exit_cnt[i] > debounce_exit_i)
						begin
							next_s.mov_status[i] = 1'b0;
						end
					end
					if (next_s.mov_status[i])
					begin
						next_s.still_cnt[i] = '0;
					end
					else
					begin
						next_s.still_cnt[i] = cbtu_inc(s.still_cnt[i]);
						if (next_s.still_cnt[i] > movement_timeout_i)
						begin
							rsd[i] = 1'b1;
						end
					end
				end
				else
				begin
					next_s.mov_status[i] = 1'b0;
					next_s.enter_cnt[i] = '0;
					next_s.exit_cnt[i] = '0;
					next_s.still_cnt[i] = '0;
				end
				if (!evt[i])
				begin
					next_s.long_term_average[i] = cbtu_iir(s.long_term_average[i], counts_i[i], lta_beta_i);
				end
				if (!s.seeded[i])
				begin
					rsd[i] = 1'b1;
				end
			end
			for (int i = 0; i < CBTU_NCH; i++)
			begin
				sel = reference_select_i[i];
				if (role_i[i] == CBTU_FOLLOW && evt[i] && !rsd[i] && 32'(sel) < CBTU_NCH)
				begin
					chg = cbtu_sdiff(next_s.long_term_average[sel], s.long_term_average[sel]);
					adj = (CBTU_WPROD_W'(chg) * CBTU_WPROD_W'($signed({1'b0, follower_weight_i[i]}))) >>> CBTU_WEIGHT_SHIFT;
					sum = $signed({{(CBTU_WPROD_W - CBTU_CW){1'b0}}, s.long_term_average[i]}) - adj;
					if (sum < 0)
					begin
						next_s.long_term_average[i] = '0;
					end
					else if (sum > $signed({{(CBTU_WPROD_W - CBTU_CW){1'b0}}, CBTU_AVG_MAX}))
					begin
						next_s.long_term_average[i] = CBTU_AVG_MAX;
					end
					else
					begin
						next_s.long_term_average[i] = sum[CBTU_CW-1:0];
					end
				end
			end
			for (int i = 0; i < CBTU_NCH; i++)
			begin
				if (rsd[i])
				begin
					next_s.long_term_average[i] = counts_i[i];
					next_s.act[i] = counts_i[i];
					next_s.mov[i] = counts_i[i];
					next_s.seeded[i] = 1'b1;
					next_s.clear[i] = 1'b1;
					next_s.snapped[i] = 1'b0;
					next_s.settle_cnt[i] = '0;
					next_s.still_cnt[i] = '0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign long_term_average_o = s.long_term_average;
	assign activation_average_o = s.act;
	assign movement_average_o = s.mov;
	assign delta_snapshot_o = s.snap;
	assign movement_status_o = s.mov_status;
	assign state_clear_o = s.clear;
	assign ati_block_o = s.ati_block;

	// Checks on channel 0 and 1 behaviour, and on the averages of all channels without sample
	default clocking cbtu_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	property p_lta_frozen;
		sample_i && (prox_i[0] || touch_i[0]) && role_i[0] != CBTU_FOLLOW
			|=> state_clear_o[0] || long_term_average_o[0] == $past(long_term_average_o[0]);
	endproperty
	a_lta_frozen: assert property (p_lta_frozen) else $error("average moved during event");

	property p_reseed_loads;
		state_clear_o[0] |-> long_term_average_o[0] == activation_average_o[0]
			&& long_term_average_o[0] == movement_average_o[0];
	endproperty
	a_reseed_loads: assert property (p_reseed_loads) else $error("reseed left averages apart");

	property p_clear_on_sample;
		state_clear_o[0] |-> $past(sample_i);
	endproperty
	a_clear_on_sample: assert property (p_clear_on_sample) else $error("clear without sample");

	property p_idle_stable;
		!sample_i |=> $stable(long_term_average_o) && $stable(activation_average_o)
			&& $stable(movement_average_o) && $stable(delta_snapshot_o);
	endproperty
	a_idle_stable: assert property (p_idle_stable) else $error("average moved without sample");

	property p_ati_block;
		role_i[1] == CBTU_REFER && (follower_event_mask_i[1]
			& {touch_i[2], prox_i[2], touch_i[1], prox_i[1], touch_i[0], prox_i[0]}) != 6'h00
			|=> ati_block_o[1];
	endproperty
	a_ati_block: assert property (p_ati_block) else $error("tuning not blocked");

	property p_ati_only_ref;
		role_i[1] != CBTU_REFER |=> !ati_block_o[1];
	endproperty
	a_ati_only_ref: assert property (p_ati_only_ref) else $error("block on non-reference");

	property p_mov_off;
		sample_i && !motion_hold_enable_i[0] |=> !movement_status_o[0];
	endproperty
	a_mov_off: assert property (p_mov_off) else $error("movement set while disabled");

	property p_rel_off;
		sample_i && !rate_release_enable_i[0] |=> delta_snapshot_o[0] == 16'h0000;
	endproperty
	a_rel_off: assert property (p_rel_off) else $error("snapshot kept while disabled");

	property p_mov_rise;
		$rose(movement_status_o[0]) |-> $past(sample_i) && $past(motion_hold_enable_i[0]);
	endproperty
	a_mov_rise: assert property (p_mov_rise) else $error("movement rose off sample");

	property p_snap_event;
		$changed(delta_snapshot_o[0]) && delta_snapshot_o[0] != 16'h0000
			|-> $past(prox_i[0]) || $past(touch_i[0]);
	endproperty
	a_snap_event: assert property (p_snap_event) else $error("snapshot outside event");

	c_reseed: cover property (state_clear_o[0] ##1 !state_clear_o[0]);
	c_mov_rise: cover property ($rose(movement_status_o[0]));
	c_ati_block: cover property (ati_block_o[1]);
	c_snapshot: cover property ($changed(delta_snapshot_o[0]) && delta_snapshot_o[0] != 16'h0000);
endmodule : cbtu_core

// [tb/cbtu_front_model.sv]
// Front end model: conversion strobe, counts and event levels
`timescale 1ns/10ps
module cbtu_front_model
(
	input wire logic sys_clk_i,
	input wire logic [cbtu_pkg::CBTU_NCH-1:0] state_clear_i,
	output logic sample_o,
	output logic [cbtu_pkg::CBTU_NCH-1:0][cbtu_pkg::CBTU_CW-1:0] counts_o,
	output logic [cbtu_pkg::CBTU_NCH-1:0] prox_o,
	output logic [cbtu_pkg::CBTU_NCH-1:0] touch_o
);
	import cbtu_pkg::*;
	initial
	begin
		sample_o = 1'b0;
		counts_o = '0;
		prox_o = '0;
		touch_o = '0;
	end
	// Reseed pulse ends event states
	always @(posedge sys_clk_i)
	begin
		prox_o <= prox_o & ~state_clear_i;
		touch_o <= touch_o & ~state_clear_i;
	end
	task automatic set_ev(input logic [CBTU_NCH-1:0] p, input logic [CBTU_NCH-1:0] t);
		prox_o = p;
		touch_o = t;
	endtask : set_ev
	// Counts valid with strobe only, inverted otherwise
	task automatic smp(input logic [CBTU_NCH-1:0][CBTU_CW-1:0] c, input int n);
		sample_o = 1'b1;
		counts_o = c;
		repeat (n) @(posedge sys_clk_i);
		#1;
		sample_o = 1'b0;
		counts_o = ~c;
	endtask : smp
endmodule : cbtu_front_model

// [tb/channel_baseline_tracking_ui_tb.sv]
// Self-checking bench for the channel baseline tracking block
`timescale 1ns/10ps
module channel_baseline_tracking_ui_tb;
	import cbtu_pkg::*;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic sample_i;
	logic [CBTU_NCH-1:0][CBTU_CW-1:0] counts_i, follower_weight_i;
	logic [CBTU_NCH-1:0] prox_i, touch_i, rate_release_enable_i, motion_hold_enable_i;
	cbtu_role_type [CBTU_NCH-1:0] role_i;
	logic [CBTU_NCH-1:0][CBTU_SEL_W-1:0] reference_select_i;
	logic [CBTU_NCH-1:0][CBTU_MASK_W-1:0] follower_event_mask_i;
	logic [CBTU_BETA_W-1:0] lta_beta_i, activation_beta_i, movement_beta_i;
	logic [CBTU_CW-1:0] settle_threshold_i, snapshot_delay_i, movement_threshold_i;
	logic [CBTU_CW-1:0] debounce_enter_i, debounce_exit_i, movement_timeout_i;
	logic [CBTU_PCT_W-1:0] release_percent_i;
	logic [CBTU_NCH-1:0][CBTU_CW-1:0] long_term_average_o, activation_average_o;
	logic [CBTU_NCH-1:0][CBTU_CW-1:0] movement_average_o, delta_snapshot_o;
	logic [CBTU_NCH-1:0] movement_status_o, state_clear_o, ati_block_o;
	int failures = 0;
	int comparisons = 0;
	int k;
	always #5 sys_clk_i = ~sys_clk_i;
	cbtu_core u_dut
	(
		.sys_clk_i, .nrst_i, .sample_i, .counts_i, .prox_i, .touch_i, .role_i, .reference_select_i,
		.follower_event_mask_i, .follower_weight_i, .lta_beta_i, .rate_release_enable_i, .activation_beta_i,
		.settle_threshold_i, .snapshot_delay_i, .release_percent_i, .motion_hold_enable_i, .movement_beta_i,
		.movement_threshold_i, .debounce_enter_i, .debounce_exit_i, .movement_timeout_i, .long_term_average_o,
		.activation_average_o, .movement_average_o, .delta_snapshot_o, .movement_status_o, .state_clear_o,
		.ati_block_o
	);
	cbtu_front_model u_fe
	(
		.sys_clk_i, .state_clear_i(state_clear_o), .sample_o(sample_i), .counts_o(counts_i),
		.prox_o(prox_i), .touch_o(touch_i)
	);
	task automatic wrap_up;
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic chk_avg(input logic [CBTU_CW-1:0] got, input logic [CBTU_CW-1:0] exp, input string m);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t %s got %0d exp %0d", $time, m, got, exp);
		end
	endtask : chk_avg
	task automatic chk_flags(input logic [CBTU_NCH-1:0] got, input logic [CBTU_NCH-1:0] exp, input string m);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask : chk_flags
	task automatic roles(input cbtu_role_type r0, input cbtu_role_type r1, input cbtu_role_type r2);
		role_i[0] = r0;
		role_i[1] = r1;
		role_i[2] = r2;
	endtask : roles
	task automatic step;
		@(posedge sys_clk_i);
		#1;
	endtask : step
	// Reset, then seed every channel with one sample
	task automatic start(input logic [CBTU_CW-1:0] c);
		nrst_i = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		nrst_i = 1'b1;
		chk_flags(state_clear_o | movement_status_o | ati_block_o, 3'h0, "reset flags");
		chk_avg(long_term_average_o[0] | delta_snapshot_o[0], 16'h0000, "reset avg");
		u_fe.smp({3{c}}, 1);
		chk_flags(state_clear_o, 3'h7, "seed pulse");
		chk_avg(movement_average_o[1], c, "seed mov");
		step();
		chk_flags(state_clear_o, 3'h0, "pulse end");
	endtask : start
	task automatic t_ati;
		roles(CBTU_FOLLOW, CBTU_REFER, CBTU_REFER);
		follower_event_mask_i = {6'h08, 6'h03, 6'h03};
		start(16'h03e8);
		u_fe.set_ev(3'h0, 3'h1);
		step();
		chk_flags(ati_block_o, 3'h2, "touch ch0");
		u_fe.set_ev(3'h2, 3'h0);
		step();
		chk_flags(ati_block_o, 3'h0, "prox ch1");
		u_fe.set_ev(3'h1, 3'h2);
		step();
		chk_flags(ati_block_o, 3'h6, "prox ch0 touch ch1");
		u_fe.set_ev(3'h0, 3'h0);
	endtask : t_ati
	task automatic t_follow;
		roles(CBTU_FOLLOW, CBTU_REFER, CBTU_INDEP);
		reference_select_i = {2'h1, 2'h0, 2'h1};
		follower_weight_i = {16'h2000, 16'h2000, 16'h2000};
		lta_beta_i = 4'h2;
		start(16'h03e8);
		u_fe.set_ev(3'h0, 3'h5);
		u_fe.smp({16'h0578, 16'h0578, 16'h03e8}, 1);
		chk_avg(long_term_average_o[1], 16'h044c, "ref lta");
		chk_avg(long_term_average_o[0], 16'h0320, "follower lta");
		chk_avg(long_term_average_o[2], 16'h03e8, "indep lta");
		chk_avg(activation_average_o[2], 16'h03e8, "act off");
		chk_avg(movement_average_o[2], 16'h03e8, "mov off");
		u_fe.set_ev(3'h0, 3'h0);
	endtask : t_follow
	task automatic t_release;
		roles(CBTU_INDEP, CBTU_INDEP, CBTU_INDEP);
		rate_release_enable_i = 3'h1;
		activation_beta_i = 4'h1;
		settle_threshold_i = 16'h0032;
		snapshot_delay_i = 16'h0002;
		release_percent_i = 8'h40;
		start(16'h03e8);
		u_fe.set_ev(3'h0, 3'h1);
		u_fe.smp({16'h03e8, 16'h03e8, 16'h0640}, 1);
		chk_avg(activation_average_o[0], 16'h0514, "act in touch");
		chk_avg(long_term_average_o[0], 16'h03e8, "lta frozen");
		u_fe.smp({16'h03e8, 16'h03e8, 16'h0640}, 5);
		chk_avg(delta_snapshot_o[0], 16'h0000, "snap early");
		u_fe.smp({16'h03e8, 16'h03e8, 16'h0640}, 1);
		chk_avg(delta_snapshot_o[0], 16'h0258, "snap");
		u_fe.smp({16'h03e8, 16'h03e8, 16'h0767}, 1);
		chk_flags(state_clear_o, 3'h0, "at limit");
		chk_avg(activation_average_o[0], 16'h06d1, "act step");
		u_fe.smp({16'h03e8, 16'h03e8, 16'h07fe}, 1);
		chk_flags(state_clear_o, 3'h1, "release");
		chk_avg(long_term_average_o[0] ^ activation_average_o[0], 16'h0000, "reseed la");
		chk_avg(movement_average_o[0], 16'h07fe, "reseed mov");
		step();
	endtask : t_release
	task automatic t_move;
		rate_release_enable_i = 3'h0;
		motion_hold_enable_i = 3'h1;
		movement_beta_i = 4'h4;
		movement_threshold_i = 16'h0064;
		debounce_enter_i = 16'h0002;
		debounce_exit_i = 16'h0001;
		movement_timeout_i = 16'h0004;
		start(16'h03e8);
		u_fe.set_ev(3'h0, 3'h1);
		u_fe.smp({16'h03e8, 16'h03e8, 16'h0578}, 1);
		chk_avg(movement_average_o[0], 16'h0401, "mov in touch");
		chk_flags(movement_status_o, 3'h0, "enter early");
		u_fe.smp({16'h03e8, 16'h03e8, 16'h0578}, 1);
		chk_flags(movement_status_o, 3'h1, "enter");
		u_fe.smp({16'h03e8, 16'h03e8, 16'h0578}, 1);
		chk_flags(movement_status_o, 3'h1, "enter held");
		chk_avg(movement_average_o[0], 16'h042e, "mov tracks");
		u_fe.smp({16'h03e8, 16'h03e8, 16'h042e}, 1);
		chk_flags(movement_status_o, 3'h1, "exit early");
		u_fe.smp({16'h03e8, 16'h03e8, 16'h042e}, 1);
		chk_flags(movement_status_o, 3'h0, "exit");
		k = 0;
		while (state_clear_o === 3'h0 && k < 12)
		begin
			u_fe.smp({16'h03e8, 16'h03e8, 16'h042e}, 1);
			k++;
		end
		chk_flags({2'h0, k == 4 || k == 5}, 3'h1, "timeout");
		chk_flags(state_clear_o, 3'h1, "timeout ch");
		chk_avg(long_term_average_o[0], 16'h042e, "timeout lta");
		step();
	endtask : t_move
	initial
	begin
		roles(CBTU_INDEP, CBTU_INDEP, CBTU_INDEP);
		reference_select_i = '0;
		follower_event_mask_i = '0;
		follower_weight_i = '0;
		lta_beta_i = 4'h2;
		activation_beta_i = 4'h1;
		movement_beta_i = 4'h4;
		rate_release_enable_i = 3'h0;
		motion_hold_enable_i = 3'h0;
		settle_threshold_i = 16'h0000;
		snapshot_delay_i = 16'h0000;
		release_percent_i = 8'h00;
		movement_threshold_i = 16'h0000;
		debounce_enter_i = 16'h0000;
		debounce_exit_i = 16'h0000;
		movement_timeout_i = 16'hffff;
		t_ati();
		t_follow();
		t_release();
		t_move();
		wrap_up();
	end
endmodule : channel_baseline_tracking_ui_tb
